// ### logic/sg_regs.svh
// Purpose: Register offsets, field positions, reset values and timing counts of the sound block
// Assumes: AXI4-Lite byte addresses, one aligned 32-bit word per register
// Notes: Sixteen-bit registers sit in the low half of the word
`ifndef SG_REGS_SVH
`define SG_REGS_SVH

// ----------------------------------------------------------------
// Offsets
// ----------------------------------------------------------------
`define SG_OFS_CLK 8'h00
`define SG_OFS_SEL 8'h04
`define SG_OFS_CTL 8'h08
`define SG_OFS_DAT 8'h0c
`define SG_OFS_FLG 8'h10
`define SG_OFS_IEN 8'h14

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SG_CLK_DEBUG_RUN 8
`define SG_SEL_DRIVE 2
`define SG_CTL_STOP 8
`define SG_CTL_EN 0
`define SG_DAT_TIE 15
`define SG_DAT_REST 14
`define SG_FLG_BUSY 8
`define SG_FLG_EMPTY 1
`define SG_FLG_DONE 0

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define SG_DAT_RESET 16'h00ff
`define SG_EMPTY_RESET 1'b1
`define SG_CLK_HZ 100000000
`define SG_SRC_HZ 32768
`define SG_TICK_CYCLES (`SG_CLK_HZ / `SG_SRC_HZ)

`endif

// ### logic/sg_pkg.sv
// Purpose: Types shared by the sound block
// Assumes: Nothing beyond the register header
// Notes: Data word layout follows the buffer register
package sg_pkg;
  typedef struct packed {
    logic tie;
    logic rest;
    logic [5:0] len;
    logic [7:0] frq;
  } sg_note_type;

  typedef enum logic [1:0] {
    SG_MODE_CONT,
    SG_MODE_ONESHOT,
    SG_MODE_MELODY,
    SG_MODE_RSVD
  } sg_mode_type;

  typedef enum logic [1:0] {
    SG_IDLE,
    SG_PLAY,
    SG_STOPPING
  } sg_state_type;
endpackage : sg_pkg

// ### logic/sg_top.sv
// Purpose: Buzzer and melody sound generator with AXI4-Lite registers
// Assumes: Clock sources arrive as one-cycle enables synchronous to aclk
// Notes: Tone tables are approximated by simple counters
`timescale 1ns/1ps
`include "sg_regs.svh"

module sg_top (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Clock source ticks and debug halt
  input wire logic [3:0] src_tick,
  input wire logic debug_halt,
  // AXI4-Lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Buzzer pins and interrupt
  output logic buzzer_output_pin,
  output logic buzzer_output_pin_n,
  output logic irq
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic debug_run_r;
  logic [2:0] clock_divider_select_r;
  logic [1:0] clock_source_select_r;
  logic [3:0] tempo_duration_field_r;
  logic drive_mode_select_r;
  sg_pkg::sg_mode_type output_mode_field_r;
  logic stop_output_bit_r;
  logic block_enable_r;
  sg_pkg::sg_note_type buf_r;
  sg_pkg::sg_note_type snd_r;
  logic buf_full_r;
  logic buffer_empty_flag_r;
  logic output_complete_flag_r;
  logic buffer_empty_irq_enable_r;
  logic output_complete_irq_enable_r;
  sg_pkg::sg_state_type state_r;

  // AXI write capture
  logic aw_have_r;
  logic w_have_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      aw_addr_r <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_r <= 1'b1;
      aw_addr_r <= s_axi_awaddr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      aw_have_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_r <= 1'b1;
      w_data_r <= s_axi_wdata;
      w_strb_r <= s_axi_wstrb;
    end else if (s_axi_bvalid && s_axi_bready) begin
      w_have_r <= 1'b0;
    end
  end

  // Write commits one cycle after both halves are held
  logic wr_go;
  assign wr_go = aw_have_r && w_have_r && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      s_axi_awready <= !aw_have_r && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_have_r && !(s_axi_wvalid && s_axi_wready);
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr_r[7:2] > 6'h05) ? 2'b10 : 2'b00;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  logic wr_clk, wr_sel, wr_ctl, wr_dat, wr_flg, wr_ien;
  logic [15:0] wd;
  assign wd = w_data_r[15:0];
  always_comb begin
    wr_clk = 1'b0;
    wr_sel = 1'b0;
    wr_ctl = 1'b0;
    wr_dat = 1'b0;
    wr_flg = 1'b0;
    wr_ien = 1'b0;
    if (!wr_go) begin
      wr_clk = 1'b0;
    end else if (aw_addr_r == `SG_OFS_CLK) begin
      wr_clk = 1'b1;
    end else if (aw_addr_r == `SG_OFS_SEL) begin
      wr_sel = 1'b1;
    end else if (aw_addr_r == `SG_OFS_CTL) begin
      wr_ctl = 1'b1;
    end else if (aw_addr_r == `SG_OFS_DAT) begin
      wr_dat = (w_strb_r[1:0] == 2'b11);
    end else if (aw_addr_r == `SG_OFS_FLG) begin
      wr_flg = 1'b1;
    end else if (aw_addr_r == `SG_OFS_IEN) begin
      wr_ien = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Operating clock
  // ----------------------------------------------------------------
  // Clock settings are frozen while enabled; a divider change mid-tone would glitch
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      debug_run_r <= 1'b0;
      clock_divider_select_r <= 3'h0;
      clock_source_select_r <= 2'h0;
    end else if (wr_clk && !block_enable_r) begin
      debug_run_r <= wd[`SG_CLK_DEBUG_RUN];
      clock_divider_select_r <= wd[6:4];
      clock_source_select_r <= wd[1:0];
    end
  end

  logic src_en;
  logic [6:0] div_cnt_r;
  logic [6:0] div_mask;
  logic op_tick;
  assign src_en = src_tick[clock_source_select_r] && block_enable_r
                  && (debug_run_r || !debug_halt);
  // Reserved divider codes give no clock at all
  always_comb begin
    div_mask = 7'h00;
    if (clock_source_select_r[0]) begin
      div_mask = (clock_divider_select_r == 3'h7) ? 7'h00 : 7'h7f;
    end else begin
      div_mask = 7'h7f >> (3'h5 - clock_divider_select_r);
    end
  end
  logic div_ok;
  assign div_ok = clock_source_select_r[0] ? (clock_divider_select_r == 3'h7)
                                           : (clock_divider_select_r <= 3'h5);
  assign op_tick = src_en && div_ok && ((div_cnt_r & div_mask) == div_mask);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt_r <= 7'h00;
    end else if (src_en) begin
      div_cnt_r <= div_cnt_r + 7'h01;
    end
  end

  // ----------------------------------------------------------------
  // Select, control and enable registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tempo_duration_field_r <= 4'h0;
      drive_mode_select_r <= 1'b0;
      output_mode_field_r <= sg_pkg::SG_MODE_CONT;
    end else if (wr_sel) begin
      tempo_duration_field_r <= wd[11:8];
      drive_mode_select_r <= wd[`SG_SEL_DRIVE];
      output_mode_field_r <= sg_pkg::sg_mode_type'(wd[1:0]);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      block_enable_r <= 1'b0;
      buffer_empty_irq_enable_r <= 1'b0;
      output_complete_irq_enable_r <= 1'b0;
    end else begin
      if (wr_ctl) begin
        block_enable_r <= wd[`SG_CTL_EN];
      end
      if (wr_ien) begin
        buffer_empty_irq_enable_r <= wd[`SG_FLG_EMPTY];
        output_complete_irq_enable_r <= wd[`SG_FLG_DONE];
      end
    end
  end

  logic stop_req;
  assign stop_req = wr_ctl && wd[`SG_CTL_STOP];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      buf_r <= sg_pkg::sg_note_type'(`SG_DAT_RESET);
    end else if (wr_dat) begin
      buf_r <= sg_pkg::sg_note_type'(wd);
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Tempo counter: 512 ticks per quarter at code 0, scaled by (code+1)
  logic [15:0] time_cnt_r;
  logic [15:0] time_end;
  logic [9:0] tone_cnt_r;
  logic [9:0] tone_per;
  logic tone_r;
  logic load;
  logic done;
  logic busy;
  logic mel;
  assign mel = (output_mode_field_r == sg_pkg::SG_MODE_MELODY);
  assign busy = (state_r != sg_pkg::SG_IDLE);
  // Melody note lasts (len+1) thirty-seconds; one-shot lasts (code+1) x 512 ticks
  assign time_end = mel ? 16'((16'(snd_r.len) + 16'h0001) * 16'(tempo_duration_field_r + 5'h01)
                             * 16'h0040 - 16'h0001)
                        : 16'((16'(tempo_duration_field_r) + 16'h0001) * 16'h0200 - 16'h0001);
  assign tone_per = mel ? {snd_r.frq, 2'b11} : {2'b00, snd_r.frq[5:0], 2'b11};

  logic trig;
  assign trig = op_tick && (time_cnt_r == time_end);

  always_comb begin
    load = 1'b0;
    done = 1'b0;
    case (state_r)
      sg_pkg::SG_IDLE: begin
        load = op_tick && buf_full_r;
      end
      sg_pkg::SG_PLAY: begin
        if (output_mode_field_r == sg_pkg::SG_MODE_ONESHOT) begin
          done = trig;
        end else if (mel && trig) begin
          load = buf_full_r;
          done = !buf_full_r;
        end
      end
      sg_pkg::SG_STOPPING: begin
        done = op_tick;
      end
      default: begin
        done = 1'b0;
      end
    endcase
  end

  // Load, done and counter steps need op_tick, which is dead while disabled; a stop request or data write acts without it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= sg_pkg::SG_IDLE;
    end else if (done) begin
      state_r <= sg_pkg::SG_IDLE;
    end else if (stop_req && busy) begin
      state_r <= sg_pkg::SG_STOPPING;
    end else if (load) begin
      state_r <= sg_pkg::SG_PLAY;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stop_output_bit_r <= 1'b0;
    end else if (stop_req && busy) begin
      stop_output_bit_r <= 1'b1;
    end else if (done || !busy) begin
      stop_output_bit_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      buf_full_r <= 1'b0;
      snd_r <= sg_pkg::sg_note_type'(`SG_DAT_RESET);
    end else begin
      // A write landing with a load stays pending; the older word still plays
      if (wr_dat) begin
        buf_full_r <= 1'b1;
      end else if (load) begin
        buf_full_r <= 1'b0;
      end
      if (load) begin
        snd_r <= buf_r;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      time_cnt_r <= 16'h0000;
      tone_cnt_r <= 10'h000;
      tone_r <= 1'b0;
    end else if (load || (state_r == sg_pkg::SG_IDLE)) begin
      time_cnt_r <= 16'h0000;
      tone_cnt_r <= 10'h000;
      // Tied notes keep the tone phase so no gap appears
      if (!(load && mel && buf_r.tie && busy)) begin
        tone_r <= 1'b0;
      end
    end else if (op_tick) begin
      time_cnt_r <= trig ? 16'h0000 : time_cnt_r + 16'h0001;
      if (tone_cnt_r >= tone_per) begin
        tone_cnt_r <= 10'h000;
        tone_r <= !tone_r;
      end else begin
        tone_cnt_r <= tone_cnt_r + 10'h001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Flags and pins
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      buffer_empty_flag_r <= `SG_EMPTY_RESET;
    end else if (load || stop_req) begin
      buffer_empty_flag_r <= 1'b1;
    end else if (wr_dat) begin
      buffer_empty_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      output_complete_flag_r <= 1'b0;
    end else if (done) begin
      output_complete_flag_r <= 1'b1;
    end else if (wr_dat || (wr_flg && wd[`SG_FLG_DONE])) begin
      output_complete_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
      buzzer_output_pin <= 1'b0;
      buzzer_output_pin_n <= 1'b0;
    end else begin
      irq <= (buffer_empty_flag_r && buffer_empty_irq_enable_r)
          || (output_complete_flag_r && output_complete_irq_enable_r);
      if (!busy || !block_enable_r) begin
        buzzer_output_pin <= 1'b0;
        buzzer_output_pin_n <= drive_mode_select_r;
      end else if (mel && snd_r.rest) begin
        buzzer_output_pin <= 1'b0;
        buzzer_output_pin_n <= 1'b1;
      end else begin
        buzzer_output_pin <= tone_r;
        buzzer_output_pin_n <= drive_mode_select_r ? !tone_r : 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  logic [15:0] rd;
  always_comb begin
    rd = 16'h0000;
    if (s_axi_araddr == `SG_OFS_CLK) begin
      rd = {7'h00, debug_run_r, 1'b0, clock_divider_select_r, 2'b00, clock_source_select_r};
    end else if (s_axi_araddr == `SG_OFS_SEL) begin
      rd = {4'h0, tempo_duration_field_r, 5'h00, drive_mode_select_r, output_mode_field_r};
    end else if (s_axi_araddr == `SG_OFS_CTL) begin
      rd = {7'h00, stop_output_bit_r, 7'h00, block_enable_r};
    end else if (s_axi_araddr == `SG_OFS_DAT) begin
      rd = buf_r;
    end else if (s_axi_araddr == `SG_OFS_FLG) begin
      rd = {7'h00, busy, 6'h00, buffer_empty_flag_r, output_complete_flag_r};
    end else if (s_axi_araddr == `SG_OFS_IEN) begin
      rd = {14'h0000, buffer_empty_irq_enable_r, output_complete_irq_enable_r};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_rvalid) begin
      s_axi_arready <= 1'b0;
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {16'h0000, rd};
      s_axi_rresp <= (s_axi_araddr[7:2] > 6'h05) ? 2'b10 : 2'b00;
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

endmodule : sg_top

// ### tb/sg_top_sva.sv
// Purpose: Port-level checks of the sound block
// Assumes: Offsets from the register header
// Notes: Shadow of the irq enable comes from completed bus writes
`timescale 1ns/1ps
`include "sg_regs.svh"

module sg_top_sva (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pins
  input wire logic buzzer_output_pin,
  input wire logic buzzer_output_pin_n,
  input wire logic irq
);
  logic [7:0] rd_addr_r;
  logic [7:0] wr_addr_r;
  logic [1:0] wr_low_r;
  logic [1:0] ien_sh_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_addr_r <= 8'h00;
      wr_addr_r <= 8'h00;
      wr_low_r <= 2'b00;
    end else begin
      if (s_axi_arvalid && s_axi_arready) rd_addr_r <= s_axi_araddr;
      if (s_axi_awvalid && s_axi_awready) wr_addr_r <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) wr_low_r <= s_axi_wdata[1:0];
    end
  end

  // Updated only after the response, so the real enable has settled at least a cycle earlier
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ien_sh_r <= 2'b00;
    end else if (s_axi_bvalid && s_axi_bready && wr_addr_r == `SG_OFS_IEN) begin
      ien_sh_r <= wr_low_r;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence aw_hs;
    s_axi_awvalid && s_axi_awready;
  endsequence
  sequence w_hs;
    s_axi_wvalid && s_axi_wready;
  endsequence

  AST_WR_ANSWER: assert property ((aw_hs and w_hs) |-> ##[1:3] s_axi_bvalid)
    else $error("write response missing");
  AST_AW_BLOCKED: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  AST_RD_REFUSE: assert property (s_axi_rvalid && rd_addr_r[7:2] > 6'h05 |-> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  AST_WR_REFUSE: assert property (s_axi_bvalid && wr_addr_r[7:2] > 6'h05 |-> s_axi_bresp == 2'b10)
    else $error("unmapped write not refused");
  AST_IRQ_MASKED: assert property (ien_sh_r == 2'b00 |-> !irq)
    else $error("irq with all enables clear");
  AST_RST_IDLE: assert property (disable iff (1'b0) !aresetn |=> !buzzer_output_pin && !buzzer_output_pin_n && !irq)
    else $error("outputs active in reset");
  AST_READY_REL: assert property ($rose(aresetn) |=> s_axi_awready && s_axi_wready && s_axi_arready)
    else $error("bus not ready after reset");
endmodule : sg_top_sva

bind sg_top sg_top_sva u_sva (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready, .buzzer_output_pin, .buzzer_output_pin_n, .irq);

// ### tb/sg_buzzer_model.sv
// Purpose: Piezo load on the pin pair
// Assumes: Pins are registered on aclk
// Notes: Only transitions matter to a piezo, so it counts the rising ones
`timescale 1ns/1ps

module sg_buzzer_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Pin pair
  input wire logic pin,
  input wire logic pin_n,
  // Rising edges seen on the true and the inverted pin
  output logic [15:0] edge_count,
  output logic [15:0] edge_count_n
);
  logic pin_r;
  logic pin_n_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_r <= 1'b0;
      pin_n_r <= 1'b0;
      edge_count <= 16'h0000;
      edge_count_n <= 16'h0000;
    end else begin
      pin_r <= pin;
      pin_n_r <= pin_n;
      if (pin && !pin_r) edge_count <= edge_count + 16'h0001;
      if (pin_n && !pin_n_r) edge_count_n <= edge_count_n + 16'h0001;
    end
  end
endmodule : sg_buzzer_model

// ### tb/tb_top.sv
// Purpose: Register-level test of the sound block
// Assumes: All clock sources tick every other cycle
// Notes: One-shot output is stopped early, so long durations are never waited out
`timescale 1ns/1ps
`include "sg_regs.svh"

module tb_top;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] src_tick = 4'h0;
  logic debug_halt = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  logic buzzer_output_pin;
  logic buzzer_output_pin_n;
  logic irq;
  logic [15:0] buzz_edges;
  logic [15:0] buzz_edges_n;
  int errors = 0;
  int check_count = 0;
  logic [31:0] rst_val [6] = '{32'h0, 32'h0, 32'h0, 32'h0000_00ff, 32'h0000_0002, 32'h0};

  sg_top DUT (.aclk, .aresetn, .src_tick, .debug_halt, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .buzzer_output_pin, .buzzer_output_pin_n, .irq);
  sg_buzzer_model u_buzz (.aclk(aclk), .aresetn(aresetn), .pin(buzzer_output_pin),
    .pin_n(buzzer_output_pin_n), .edge_count(buzz_edges), .edge_count_n(buzz_edges_n));

  initial begin
    forever #5 aclk = ~aclk;
  end

  always @(posedge aclk) src_tick <= ~src_tick;

  // ----------------------------------------------------------------
  // Bus tasks and compares
  // ----------------------------------------------------------------
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t word %h expected %h", $time, got, exp);
    end
  endtask : check_word

  task automatic check_bits(input logic [1:0] got, input logic [1:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t bits %b expected %b", $time, got, exp);
    end
  endtask : check_bits

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf,
                    input logic [1:0] er = 2'b00);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && s_axi_awready) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do begin
      @(posedge aclk);
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    check_bits(s_axi_bresp, er);
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er = 2'b00);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
    end while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do begin
      @(posedge aclk);
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    check_bits(s_axi_rresp, er);
    check_word(s_axi_rdata, exp);
    @(posedge aclk);
  endtask : rd

  // Queue a tone, optionally held off by debug halt until released, then stop it early
  task automatic play_stop(input logic [1:0] m, input logic h);
    logic [15:0] e0;
    logic [15:0] en0;
    // Normal drive on the pin pair when not halted, direct drive otherwise
    wr(`SG_OFS_SEL, {29'h0, ~h, m});
    debug_halt <= h;
    wr(`SG_OFS_DAT, 32'h0000_0804);
    repeat (20) @(posedge aclk);
    rd(`SG_OFS_FLG, {23'h0, ~h, 6'h0, ~h, 1'b0});
    check_bits({1'b0, irq}, {1'b0, ~h});
    debug_halt <= 1'b0;
    e0 = buzz_edges;
    en0 = buzz_edges_n;
    repeat (200) @(posedge aclk);
    check_bits({buzz_edges != e0, buzz_edges_n != en0}, {1'b1, ~h});
    rd(`SG_OFS_FLG, 32'h0000_0102);
    wr(`SG_OFS_CTL, 32'h0000_0101);
    repeat (10) @(posedge aclk);
    rd(`SG_OFS_FLG, 32'h0000_0003);
    rd(`SG_OFS_CTL, 32'h0000_0001);
  endtask : play_stop

  task automatic summarize;
    if (errors == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 6; i++) rd(8'(i * 4), rst_val[i]);
    rd(8'h18, 32'h0, 2'b10);
    wr(8'h18, 32'h1, 4'hf, 2'b10);
    wr(`SG_OFS_CLK, 32'h0000_0071);
    wr(`SG_OFS_CTL, 32'h0000_0001);
    wr(`SG_OFS_CLK, 32'h0000_0000);
    rd(`SG_OFS_CLK, 32'h0000_0071);
    wr(`SG_OFS_IEN, 32'h0000_0003);
    play_stop(2'd1, 1'b1);
    play_stop(2'd0, 1'b0);
    wr(`SG_OFS_FLG, 32'h0000_0001);
    rd(`SG_OFS_FLG, 32'h0000_0002);
    wr(`SG_OFS_DAT, 32'h0000_1234, 4'h1);
    rd(`SG_OFS_DAT, 32'h0000_0804);
    rd(`SG_OFS_FLG, 32'h0000_0002);
    wr(`SG_OFS_SEL, 32'h0000_0002);
    wr(`SG_OFS_DAT, 32'h0000_4000);
    rd(`SG_OFS_FLG, 32'h0000_0102);
    for (int i = 0; i < 6; i++) begin
      repeat (8) @(posedge aclk);
      check_bits({buzzer_output_pin, buzzer_output_pin_n}, 2'b01);
    end
    repeat (400) @(posedge aclk);
    rd(`SG_OFS_FLG, 32'h0000_0003);
    wr(`SG_OFS_CTL, 32'h0000_0000);
    wr(`SG_OFS_SEL, 32'h0000_0004);
    repeat (5) @(posedge aclk);
    check_bits({buzzer_output_pin, buzzer_output_pin_n}, 2'b01);
    wr(`SG_OFS_CLK, 32'h0000_0171);
    rd(`SG_OFS_CLK, 32'h0000_0171);
    wr(`SG_OFS_IEN, 32'h0000_0000);
    summarize();
  end

  // Whole run is about a thousand cycles; this leaves wide margin
  initial begin
    #200us;
    errors++;
    summarize();
  end
endmodule : tb_top
